// file: verilog/ees_slave.sv
/*
  two-wire eeprom slave front end: framing, acknowledge, address decode,
  word address capture, write-protect gating, standby and write launch.
  assumes pins arrive asynchronous; power-on and brown-out indications are levels.
*/
`timescale 1ns/10ps
module ees_slave
  import ees_pkg::*;
#(
  parameter int INIT_CYC = EES_INIT_CYC  // power-up settle before responding
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,  // clock enable, freezes all state
  input wire logic i_scl,  // serial clock pin
  input wire logic i_sda,  // serial data pin level
  output logic o_sda,  // data pin drive value (always 0)
  output logic o_sda_oe,  // high while pulling data low
  input wire logic i_por_ok,  // power-on reset released
  input wire logic i_brownout,  // supply below brownout_threshold
  input wire logic i_hw_wp,  // hardware write-protect pin
  input wire logic i_soft_write_protect_bit,  // stored protect bit
  input wire logic i_id_locked,  // id page locked
  input wire logic i_busy,  // self-timed write cycle running
  input wire logic i_read_ack_n,  // read data engine drives low on fall
  output logic o_standby,  // low-power standby
  output logic o_write_launch,  // pulse: start self-timed write
  output logic o_read_active,  // read phase owns data line
  output logic [2:0] o_op,  // selected operation
  output logic [10:0] o_array_addr,  // array address incl. top bits
  output logic [3:0] o_id_page_byte_offset,  // byte within id page
  output logic [7:0] o_data,  // last accepted data byte
  output logic o_data_valid  // pulse: data byte accepted
);
  // all protocol state in one record, control synchronisers included
  typedef struct packed {
    ees_state_e st;  // protocol phase
    ees_op_e op;  // chosen operation
    logic [7:0] sh;  // receive shifter
    logic [3:0] bitn;  // bit count within byte, 8 = ack slot
    logic ack;  // drive ack during slot
    logic acked_data;  // at least one data byte accepted
    logic in_ack;  // currently in ack slot
    logic is_write;  // direction of current command
    logic [10:0] addr;  // array address
    logic [3:0] idoff;  // id page offset
    logic [7:0] data;  // data byte register
    logic dvalid;  // data accepted pulse
    logic launch;  // write launch pulse
    logic [1:0] por_sync;  // power-on sync chain
    logic [1:0] bor_sync;  // brownout sync chain
    logic [1:0] wp_sync;  // write-protect sync chain
    logic ready;  // settle done after power-on
    logic [$clog2(INIT_CYC+1)-1:0] settle;  // settle counter, sized by the parameter
  } ees_core_s;
  ees_core_s c_q, c_d;

  ees_pin_if ev ();

  // pin synchronisers and event detection
  ees_pin_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .ev(ev)
  );

  // true when the selected array or id page write is protected
  function automatic logic wp_blocks(input logic wp, input logic soft_write_protect_bit, input ees_op_e op);
    wp_blocks = (wp || soft_write_protect_bit) && (op == EES_OP_ARRAY || op == EES_OP_IDPAGE);
  endfunction

  logic alive;  // powered, settled and not browned out
  logic wp_lvl;  // synchronised hardware protect
  assign alive = c_q.por_sync[1] && !c_q.bor_sync[1] && c_q.ready;
  assign wp_lvl = c_q.wp_sync[1];

  // protocol next-state logic
  always_comb
  begin
    c_d = c_q;
    c_d.dvalid = 1'b0;
    c_d.launch = 1'b0;
    c_d.por_sync = {c_q.por_sync[0], i_por_ok};
    c_d.bor_sync = {c_q.bor_sync[0], i_brownout};
    c_d.wp_sync = {c_q.wp_sync[0], i_hw_wp};
    // settle count after power-on release
    if (!c_q.por_sync[1] || c_q.bor_sync[1])
    begin
      c_d.settle = '0;
      c_d.ready = 1'b0;
    end
    else if (!c_q.ready)
    begin
      if (c_q.settle >= INIT_CYC[$bits(c_q.settle)-1:0])
        c_d.ready = 1'b1;
      else
        c_d.settle = c_q.settle + 1'b1;
    end
    if (!alive)
    begin
      // brown-out or pre-power: protocol reset, silent
      c_d.st = EES_ST_IDLE;
      c_d.ack = 1'b0;
      c_d.in_ack = 1'b0;
      c_d.op = EES_OP_NONE;
    end
    else if (ev.stop)
    begin
      // stop in tenth clock of a write after an accepted data byte
      // the tenth clock's rise has already been counted as one bit
      if (c_q.st == EES_ST_DATA && c_q.is_write && c_q.acked_data && c_q.bitn == EES_BITN_STOP && !c_q.in_ack)
        c_d.launch = 1'b1;
      c_d.st = EES_ST_IDLE;
      c_d.ack = 1'b0;
      c_d.in_ack = 1'b0;
    end
    else if (ev.start)
    begin
      // start always re-frames, recovering any broken transfer
      c_d.st = EES_ST_DEV;
      c_d.bitn = '0;
      c_d.ack = 1'b0;
      c_d.in_ack = 1'b0;
      c_d.acked_data = 1'b0;
    end
    else if (c_q.st != EES_ST_IDLE && c_q.st != EES_ST_READ)
    begin
      if (ev.scl_rise && !c_q.in_ack)
      begin
        // sample on rising edge, msb first
        c_d.sh = {c_q.sh[6:0], ev.sda};
        c_d.bitn = c_q.bitn + 1'b1;
      end
      else if (ev.scl_rise && c_q.in_ack)
        c_d.bitn = '0;
      else if (ev.scl_fall && c_q.bitn == EES_BIT_ACK && !c_q.in_ack)
      begin
        // byte complete: decide the ninth-clock answer
        c_d.in_ack = 1'b1;
        c_d.ack = 1'b0;
        case (c_q.st)
          EES_ST_DEV:
          begin
            c_d.is_write = !c_q.sh[0];
            if (c_q.sh[7:4] == EES_TYPE_ARRAY && !i_busy)
            begin
              c_d.ack = 1'b1;
              c_d.op = EES_OP_ARRAY;
              c_d.addr[10:8] = c_q.sh[3:1];
            end
            else if (c_q.sh[7:4] == EES_TYPE_SEC && !i_busy)
            begin
              c_d.ack = 1'b1;
              c_d.op = c_q.sh[0] ? EES_OP_UID : EES_OP_LOCK;
            end
          end
          EES_ST_WORD:
          begin
            c_d.ack = 1'b1;
            if (c_q.op == EES_OP_ARRAY)
              c_d.addr[7:0] = c_q.sh;
            else if (c_q.sh[7:6] == EES_FN_IDPAGE)
            begin
              c_d.op = EES_OP_IDPAGE;
              c_d.idoff = c_q.sh[3:0];
            end
            else if (c_q.sh[7:6] == EES_FN_LOCK && c_q.is_write)
              c_d.op = EES_OP_LOCK;
            else if (c_q.sh[7:6] == EES_FN_SWP)
              c_d.op = EES_OP_SWP;
            else if (!c_q.is_write)
              c_d.op = EES_OP_UID;
            else
              c_d.ack = 1'b0;
          end
          EES_ST_DATA:
          begin
            // protected or locked writes refused per data byte
            if (!wp_blocks(wp_lvl, i_soft_write_protect_bit, c_q.op)
                && !((c_q.op == EES_OP_IDPAGE || c_q.op == EES_OP_LOCK) && i_id_locked))
            begin
              c_d.ack = 1'b1;
              c_d.acked_data = 1'b1;
              c_d.data = c_q.sh;
              c_d.dvalid = 1'b1;
            end
          end
          default:
            c_d.ack = 1'b0;
        endcase
      end
      else if (ev.scl_fall && c_q.in_ack)
      begin
        // end of ninth clock: advance, stay in data after a refused data byte, or return to standby
        c_d.in_ack = 1'b0;
        c_d.ack = 1'b0;
        c_d.bitn = '0;
        if (!c_q.ack)
          c_d.st = (c_q.st == EES_ST_DATA) ? EES_ST_DATA : EES_ST_IDLE;
        else
          case (c_q.st)
            EES_ST_DEV:
              c_d.st = c_q.is_write ? EES_ST_WORD : EES_ST_READ;
            EES_ST_WORD:
              c_d.st = c_q.is_write ? EES_ST_DATA : EES_ST_READ;
            EES_ST_DATA:
              c_d.st = EES_ST_DATA;
            default:
              c_d.st = EES_ST_IDLE;
          endcase
      end
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      c_q <= '0;
    else if (i_ce)
      c_q <= c_d;
  end

  // line driven low only for ack slot or read engine; changes follow falls
  assign o_sda = 1'b0;
  assign o_sda_oe = (c_q.ack && c_q.in_ack) || (c_q.st == EES_ST_READ && !i_read_ack_n);
  assign o_standby = (c_q.st == EES_ST_IDLE) && !i_busy;
  assign o_write_launch = c_q.launch;
  assign o_read_active = (c_q.st == EES_ST_READ);
  assign o_op = c_q.op;
  assign o_array_addr = c_q.addr;
  assign o_id_page_byte_offset = c_q.idoff;
  assign o_data = c_q.data;
  assign o_data_valid = c_q.dvalid;

  // ack driven at the rise of the ninth clock
  sequence s_ack_slot;
    c_q.in_ack && c_q.ack && ev.scl_rise;
  endsequence
  a_ack_held: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_ack_slot |-> o_sda_oe)
    else $error("ack released during ninth clock");
  // stop always closes the transaction
  a_stop_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && alive && ev.stop) |=> c_q.st == EES_ST_IDLE)
    else $error("stop did not end transaction");
  // start always re-frames at bit zero
  a_start_frame: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && alive && ev.start && !ev.stop) |=> (c_q.st == EES_ST_DEV && c_q.bitn == '0))
    else $error("start did not reframe");
  // brownout drops the protocol at once
  a_bor_silent: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && c_q.bor_sync[1]) |=> (c_q.st == EES_ST_IDLE && !c_q.ack))
    else $error("brownout left protocol active");
  // protect pin refuses array data bytes
  a_wp_nack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (c_q.st == EES_ST_DATA && c_q.in_ack && wp_lvl && c_q.op == EES_OP_ARRAY) |-> !o_sda_oe)
    else $error("protected data byte acknowledged");
  // protect bit refuses id page data bytes
  a_swp_nack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (c_q.st == EES_ST_DATA && c_q.in_ack && i_soft_write_protect_bit && c_q.op == EES_OP_IDPAGE) |-> !o_sda_oe)
    else $error("soft protected data byte acknowledged");
  // a launch only ever follows a write data phase
  a_launch_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_write_launch |-> ($past(c_q.st) == EES_ST_DATA && $past(c_q.is_write)))
    else $error("write launched outside a write");
  // only the two identifiers 101x are ever answered
  a_bad_type: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (c_q.st == EES_ST_DEV && c_q.in_ack && c_q.sh[7:5] != EES_TYPE_ARRAY[3:1]) |-> !o_sda_oe)
    else $error("foreign address acknowledged");
  // standby never touches the line
  a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (c_q.st == EES_ST_IDLE) |-> !o_sda_oe)
    else $error("line driven while idle");

  // a receiving phase sees a clock rise outside the ack slot
  sequence s_bit_taken;
    i_ce && alive && ev.scl_rise && !c_q.in_ack
      && (c_q.st == EES_ST_DEV || c_q.st == EES_ST_WORD || c_q.st == EES_ST_DATA);
  endsequence
  // the eighth fall of a byte opens the ninth clock
  sequence s_byte_end;
    i_ce && alive && ev.scl_fall && !c_q.in_ack && c_q.bitn == EES_BIT_ACK
      && (c_q.st == EES_ST_DEV || c_q.st == EES_ST_WORD || c_q.st == EES_ST_DATA);
  endsequence
  // the fall that ends the ninth clock
  sequence s_slot_end;
    i_ce && alive && ev.scl_fall && c_q.in_ack
      && (c_q.st == EES_ST_DEV || c_q.st == EES_ST_WORD || c_q.st == EES_ST_DATA);
  endsequence
  // bit taken at the rise and shifted in behind the older ones
  a_bit_shift: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_bit_taken |=> (c_q.sh[0] == $past(ev.sda) && c_q.sh[7:1] == $past(c_q.sh[6:0])))
    else $error("data bit not shifted in on clock rise");
  // eight bits then the answer slot, no idle clock between
  a_slot_open: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_byte_end |=> c_q.in_ack)
    else $error("ninth clock slot not opened after eight bits");
  // the answer is let go after the ninth fall, never before
  a_slot_close: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_slot_end |=> (!c_q.in_ack && !c_q.ack))
    else $error("ninth clock slot not closed on its fall");
  // a refused address or word byte sends the block back to standby
  a_nack_standby: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && alive && ev.scl_fall && c_q.in_ack && !c_q.ack && (c_q.st == EES_ST_DEV || c_q.st == EES_ST_WORD))
      |=> c_q.st == EES_ST_IDLE)
    else $error("no standby after refused address");
  // a running write cycle refuses every address byte
  a_busy_refused: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && alive && ev.scl_fall && !c_q.in_ack && c_q.bitn == EES_BIT_ACK && c_q.st == EES_ST_DEV && i_busy)
      |=> !o_sda_oe)
    else $error("address acknowledged while busy");
  // stop in the tenth clock after an accepted byte starts the write
  a_launch_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && alive && ev.stop && c_q.st == EES_ST_DATA && c_q.is_write && c_q.acked_data && !c_q.in_ack
      && c_q.bitn == EES_BITN_STOP) |=> o_write_launch)
    else $error("write not launched by closing stop");
  // launch is a single-cycle pulse
  a_launch_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && o_write_launch) |=> !o_write_launch)
    else $error("write launch longer than one cycle");
  // unpowered or browned out: the line stays released
  a_dead_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && !alive) |=> !o_sda_oe)
    else $error("line driven without power");
endmodule

// file: verilog/ees_pkg.sv
/*
  constants, types and state encodings of the two-wire eeprom slave front end.
  assumes a 250 mhz system clock sampling the bus pins through synchronisers.
*/
package ees_pkg;
  localparam logic [3:0] EES_TYPE_ARRAY = 4'ha;  // main memory identifier
  localparam logic [3:0] EES_TYPE_SEC = 4'hb;  // secondary identifier
  localparam logic [1:0] EES_FN_IDPAGE = 2'h0;  // word function: id page
  localparam logic [1:0] EES_FN_LOCK = 2'h2;  // word function: lock
  localparam logic [1:0] EES_FN_SWP = 2'h3;  // word function: protect bit
  localparam logic [3:0] EES_BITS_BYTE = 4'h8;  // data bits per byte
  localparam logic [3:0] EES_BIT_ACK = 4'h8;  // bit index of ack slot
  localparam logic [3:0] EES_BITN_STOP = 4'h1;  // bits counted when stop closes the tenth clock
  localparam real EES_INIT_MS = 10.0;  // first_command_delay, ms
  localparam real EES_CLK_MHZ = 250.0;  // system clock rate
  localparam int EES_INIT_CYC = int'(EES_INIT_MS * 1000.0 * EES_CLK_MHZ);
  // protocol phases
  typedef enum logic [2:0] {
    EES_ST_IDLE = 3'b000,  // standby, waiting for start
    EES_ST_DEV = 3'b001,  // receiving address byte
    EES_ST_WORD = 3'b010,  // receiving word address byte
    EES_ST_DATA = 3'b011,  // receiving data bytes
    EES_ST_READ = 3'b100  // read phase, data engine owns the line
  } ees_state_e;
  // operation selected by address and word address
  typedef enum logic [2:0] {
    EES_OP_NONE = 3'b000,
    EES_OP_ARRAY = 3'b001,
    EES_OP_IDPAGE = 3'b010,
    EES_OP_LOCK = 3'b011,
    EES_OP_SWP = 3'b100,
    EES_OP_UID = 3'b101
  } ees_op_e;
endpackage

// file: verilog/ees_pin_if.sv
/*
  interface carrying the synchronised bus events from the pin stage to the core.
  assumes both ends share i_sys_clk.
*/
`timescale 1ns/10ps
interface ees_pin_if;
  logic scl_rise;  // clock rising edge pulse
  logic scl_fall;  // clock falling edge pulse
  logic sda;  // synchronised data level
  logic start;  // start event pulse
  logic stop;  // stop event pulse
  modport src (output scl_rise, scl_fall, sda, start, stop);
  modport dst (input scl_rise, scl_fall, sda, start, stop);
endinterface

// file: verilog/ees_pin_sync.sv
/*
  two-flop synchronisers on the bus pins and edge/start/stop event detection.
  assumes raw asynchronous pin levels; events are decoded from the second flop with no added cycle.
*/
`timescale 1ns/10ps
module ees_pin_sync
  import ees_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda,
  ees_pin_if.src ev
);
  // all state in one record
  typedef struct packed {
    logic [1:0] scl_sync;  // [0] first flop, [1] second flop
    logic [1:0] sda_sync;
    logic scl_prev;  // previous stable clock sample
    logic sda_prev;
  } ees_sync_s;
  ees_sync_s s_q, s_d;

  // next state: shift synchronisers, keep last stable sample
  always_comb
  begin
    s_d = s_q;
    s_d.scl_sync = {s_q.scl_sync[0], i_scl};
    s_d.sda_sync = {s_q.sda_sync[0], i_sda};
    s_d.scl_prev = s_q.scl_sync[1];
    s_d.sda_prev = s_q.sda_sync[1];
  end

  // registered state, idle bus is high
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_q <= '1;
    else if (i_ce)
      s_q <= s_d;
  end

  // events only from second-stage samples
  assign ev.sda = s_q.sda_sync[1];
  assign ev.scl_rise = i_ce && s_q.scl_sync[1] && !s_q.scl_prev;
  assign ev.scl_fall = i_ce && !s_q.scl_sync[1] && s_q.scl_prev;
  // data change while clock high and steady
  assign ev.start = i_ce && s_q.scl_sync[1] && s_q.scl_prev && s_q.sda_prev && !s_q.sda_sync[1];
  assign ev.stop = i_ce && s_q.scl_sync[1] && s_q.scl_prev && !s_q.sda_prev && s_q.sda_sync[1];
endmodule

// file: tb/ees_master_model.sv
/*
  bus master model: drives the serial clock and pulls the data line low.
  assumes the bench resolves the data wire with a pull-up; clock idles high.
  pin changes are kept on the bench clock's falling edge, away from its sampling edge.
*/
`timescale 1ns/10ps
module ees_master_model
(
  input wire logic i_clk,  // bench clock, only used to place pin changes
  output logic o_scl,  // serial clock, stands high outside frames
  output logic o_sda_oe,  // high while the master pulls data low
  input wire logic i_sda  // resolved data wire
);
  // idle bus: clock high, data released
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // start, also a repeated start from clock low
  task automatic start();
    @(negedge i_clk);
    o_sda_oe = 1'b0;
    #8 o_scl = 1'b1;
    #8 o_sda_oe = 1'b1;
    #16 o_scl = 1'b0;
    #8;
  endtask
  // stop, entered with the clock low
  task automatic stop();
    o_sda_oe = 1'b1;
    #8 o_scl = 1'b1;
    #8 o_sda_oe = 1'b0;
    #16;
  endtask
  // one clock; data set mid-low, line sampled just after the rise and just before the fall
  task automatic pulse(input logic bit_v, output logic low_seen);
    o_sda_oe = !bit_v;
    #8 o_scl = 1'b1;
    #1 low_seen = !i_sda;
    #14 low_seen = low_seen & !i_sda;
    #1 o_scl = 1'b0;
    #8;
  endtask
  // eight bits msb first, then the released ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    @(negedge i_clk);
    for (int i = 7; i >= 0; i--)
    begin
      pulse(b[i], s);
    end
    pulse(1'b1, ack);
    #8;  // longer low phase so the slave lets go in time
  endtask
endmodule

// file: tb/ees_slave_tb_top.sv
/*
  self-checking bench of the eeprom slave front end with a bus master model.
  assumes the design's INIT_CYC may be shortened; bus clock period is 32 ns.
*/
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module ees_slave_tb_top;
  import ees_pkg::*;
  logic clk, rst_n, por_ok, brownout, hw_wp, soft_write_protect_bit, id_locked, busy;  // design inputs
  logic m_scl, m_oe, dut_sda, dut_oe, standby, launch, read_active, data_valid;
  logic [2:0] op;  // selected operation
  logic [10:0] array_addr;  // captured array address
  logic [3:0] page_off;  // id page byte
  logic [7:0] data;  // last accepted byte
  logic a0, a1, a2;  // acks of address, word and data bytes
  wire sda_w = !(m_oe || (dut_oe && !dut_sda));  // pull-up wire
  int fails = 0;
  int comparisons = 0;
  int dv_cnt = 0;  // accepted data bytes
  int wl_cnt = 0;  // write launches
  // bench clock, reset is driven by the main sequence
  initial
  begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  // pulse counters
  always @(posedge clk)
  begin
    if (data_valid === 1'b1) dv_cnt++;
    if (launch === 1'b1) wl_cnt++;
  end
  ees_master_model i_m (.i_clk(clk), .o_scl(m_scl), .o_sda_oe(m_oe), .i_sda(sda_w));
  ees_slave #(.INIT_CYC(8)) i_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_scl(m_scl), .i_sda(sda_w),
    .o_sda(dut_sda), .o_sda_oe(dut_oe), .i_por_ok(por_ok), .i_brownout(brownout),
    .i_hw_wp(hw_wp), .i_soft_write_protect_bit(soft_write_protect_bit), .i_id_locked(id_locked),
    .i_busy(busy), .i_read_ack_n(1'b1), .o_standby(standby), .o_write_launch(launch),
    .o_read_active(read_active), .o_op(op), .o_array_addr(array_addr),
    .o_id_page_byte_offset(page_off), .o_data(data), .o_data_valid(data_valid)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // array byte write, launch on stop
  task automatic t_write();
    int dv;
    int wl;
    dv = dv_cnt;
    wl = wl_cnt;
    i_m.start();
    `CHK(standby, 1'b0)
    i_m.send_byte(8'ha6, a0);
    `CHK(a0, 1'b1)
    i_m.send_byte(8'h12, a1);
    `CHK(a1, 1'b1)
    `CHK(array_addr, 11'h312)
    `CHK(op, 3'h1)
    i_m.send_byte(8'h55, a2);
    `CHK(data, 8'h55)
    `CHK(dv_cnt - dv, 1)
    `CHK(wl_cnt, wl)
    i_m.stop();
    cyc(8);
    `CHK(wl_cnt - wl, 1)
  endtask
  // read address then stop: standby, no launch
  task automatic t_read();
    int wl;
    wl = wl_cnt;
    i_m.start();
    i_m.send_byte(8'ha1, a0);
    `CHK(a0, 1'b1)
    `CHK(read_active, 1'b1)
    i_m.stop();
    cyc(8);
    `CHK(standby, 1'b1)
    `CHK(wl_cnt, wl)
    i_m.start();
    i_m.send_byte(8'hb1, a0);
    `CHK(a0, 1'b1)
    `CHK(op, 3'h5)
    `CHK(read_active, 1'b1)
    i_m.stop();
  endtask
  // secondary identifier with each word function
  task automatic t_sec();
    logic [7:0] w [3] = '{8'h05, 8'h80, 8'hc0};
    logic [2:0] o [3] = '{3'h2, 3'h3, 3'h4};
    for (int i = 0; i < 3; i++)
    begin
      i_m.start();
      i_m.send_byte(8'hbe, a0);
      i_m.send_byte(w[i], a1);
      `CHK(a0 & a1, 1'b1)
      `CHK(op, o[i])
      if (i == 0) `CHK(page_off, 4'h5)
      i_m.stop();
    end
  endtask
  // protect pin, protect bit, locked page: data nacked, nothing launched
  task automatic t_prot();
    int wl;
    wl = wl_cnt;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      hw_wp <= (i == 0);
      soft_write_protect_bit <= (i == 1);
      id_locked <= (i == 2);
      cyc(4);
      i_m.start();
      i_m.send_byte((i == 2) ? 8'hb0 : 8'ha0, a0);
      i_m.send_byte((i == 2) ? 8'h01 : 8'h00, a1);
      `CHK(a0 & a1, 1'b1)
      i_m.send_byte(8'h33, a2);
      `CHK(a2, 1'b0)
      i_m.stop();
    end
    `CHK(wl_cnt, wl)
    @(posedge clk);
    id_locked <= 1'b0;
  endtask
  // no start, brownout, busy, unknown type: all nacked
  task automatic t_refuse();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      brownout <= (i == 1);
      busy <= (i == 2);
      cyc(4);
      if (i != 0) i_m.start();
      i_m.send_byte((i == 3) ? 8'h90 : 8'ha0, a0);
      `CHK(a0, 1'b0)
      i_m.stop();
      @(posedge clk);
      brownout <= 1'b0;
      busy <= 1'b0;
      cyc(30);
      `CHK(standby, 1'b1)
    end
  endtask
  // broken byte, then start, nine clocks, start, stop
  task automatic t_recover();
    logic s;
    i_m.start();
    i_m.send_byte(8'ha6, a0);
    repeat (4) i_m.pulse(1'b0, s);
    i_m.start();
    repeat (9) i_m.pulse(1'b1, s);
    i_m.start();
    i_m.stop();
    cyc(8);
    `CHK(standby, 1'b1)
    t_write();
  endtask
  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #200000;
    fails++;
    finish_test();
  end
  // main sequence
  initial
  begin
    {rst_n, por_ok, brownout, hw_wp, soft_write_protect_bit, id_locked, busy} = 7'h0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(4);
    `CHK(standby, 1'b1)
    i_m.start();
    i_m.send_byte(8'ha0, a0);
    `CHK(a0, 1'b0)
    i_m.stop();
    @(posedge clk);
    por_ok <= 1'b1;
    cyc(30);
    t_write();
    t_read();
    t_sec();
    t_prot();
    t_refuse();
    t_recover();
    finish_test();
  end
endmodule
